/* File: logic/svpm_pkg.sv */
package svpm_pkg;

    // Clock and time base.
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned MS_IN_NS = 1000000;
    localparam int unsigned CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
    localparam int unsigned MS_CNT_W = 17;

    // Register byte offsets.
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] A_MODE = 8'h00;
    localparam logic [7:0] A_INHIBIT_FUNC = 8'h04;
    localparam logic [7:0] A_CLEAR_FUNC = 8'h08;
    localparam logic [7:0] A_OUTPUT4_FUNC = 8'h0C;
    localparam logic [7:0] A_COIN_FUNC = 8'h10;
    localparam logic [7:0] A_THRESHOLD = 8'h14;
    localparam logic [7:0] A_JUDGE_TIME = 8'h18;
    localparam logic [7:0] A_DONE_TIME = 8'h1C;
    localparam logic [7:0] A_TARGET = 8'h20;
    localparam logic [7:0] A_JERK_TIME = 8'h24;
    localparam logic [7:0] A_LOWPASS_TIME = 8'h28;
    localparam logic [7:0] A_STATUS = 8'h2C;
    localparam logic [7:0] A_POS_ERROR = 8'h30;
    localparam logic [7:0] A_POS_COMMAND = 8'h34;

    // Function codes of digital inputs and outputs.
    localparam logic [15:0] FC_INPOS_CLOSED = 16'h0009;
    localparam logic [15:0] FC_INPOS_OPEN = 16'h000A;
    localparam logic [15:0] FC_CLEAR_CLOSED = 16'h0011;
    localparam logic [15:0] FC_CLEAR_OPEN = 16'h0012;
    localparam logic [15:0] FC_INHIBIT_CLOSED = 16'h0019;
    localparam logic [15:0] FC_INHIBIT_OPEN = 16'h001A;
    localparam logic [15:0] FC_COIN_CLOSED = 16'h001F;
    localparam logic [15:0] FC_COIN_OPEN = 16'h0020;

    // Values after reset.
    localparam logic [15:0] RST_OUTPUT4_FUNC = FC_INPOS_CLOSED;
    localparam logic [15:0] RST_INHIBIT_FUNC = FC_INHIBIT_CLOSED;
    localparam logic [15:0] RST_CLEAR_FUNC = FC_CLEAR_CLOSED;
    localparam logic [15:0] RST_COIN_FUNC = FC_COIN_CLOSED;
    localparam logic [15:0] RST_THRESHOLD = 16'h0028;
    localparam logic [15:0] RST_JUDGE_TIME = 16'h000A;
    localparam logic [15:0] RST_DONE_TIME = 16'h0002;
    localparam logic [31:0] RST_TARGET = 32'h0000000A;
    localparam logic [15:0] RST_JERK_TIME = 16'h000A;
    localparam logic [15:0] RST_LOWPASS_TIME = 16'h000A;

    // Ranges and tolerance.
    localparam logic [15:0] MAX_THRESHOLD = 16'h7D00;
    localparam logic [15:0] MAX_JUDGE_TIME = 16'h7D00;
    localparam logic [15:0] MAX_DONE_TIME = 16'h4E20;
    localparam logic [15:0] MAX_JERK_TIME = 16'h00FA;
    localparam logic [15:0] MAX_LOWPASS_TIME = 16'h03E8;
    localparam logic [31:0] MIN_TARGET = 32'h80000001;
    localparam logic [32:0] COIN_TOLERANCE = 33'h000000064;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        MODE_PULSE_POS = 3'h0,
        MODE_INT_POS = 3'h1,
        MODE_INT_SPD = 3'h3,
        MODE_INT_TRQ = 3'h2,
        MODE_ANA_POS = 3'h6,
        MODE_ANA_SPD = 3'h7,
        MODE_ANA_TRQ = 3'h5,
        MODE_COMM = 3'h4
    } svpm_mode_t;

endpackage

/* File: logic/svpm_top.sv */
// Notes on behaviour
// - Jerk smoothing is enabled in every mode except external pulse position.
// - Low-pass smoothing is enabled in every control mode.
// - Active inhibit in pulse position mode stops counting command pulses.
// - While inhibited, pulses are ignored and the motor halt output is raised.
// - Inhibit code 25 means closed contact active, code 26 open active.
// - Position error is command position minus encoder feedback.
// - Active clear in pulse mode holds error at zero, no compensation.
// - Clear code 17 means closed contact active, code 18 open active.
// - In position modes, in-position holds when error is below threshold.
// - Output code 9 closes on in-position, code 10 opens on it.
// - Error threshold spans 0 to 32000 pulses, default 40.
// - Motion judgment count time spans 0 to 32000 ms, default 10.
// - Pulse done detect time spans 0 to 20000 ms, default 2.
// - Output four defaults to in-position, code 9, closed when true.
// - Coincidence holds when feedback is within 100 pulses of target.
// - Coincidence code 31 closes when true, code 32 opens.
// - Target is signed, limited to plus or minus 2147483647, default 10.
// - A smoothing time constant of zero disables that filter.
`timescale 1ns/1ps
module svpm_top
    import svpm_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = CYCLES_PER_MS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pulse_step_pin,
    input wire logic pulse_dir_pin,
    input wire logic pulse_inhibit_input,
    input wire logic error_counter_clear_input,
    input wire logic [31:0] feedback_position,
    output logic [31:0] position_command,
    output logic [31:0] position_error,
    output logic position_comp_enable,
    output logic motor_halt,
    output logic digital_output_four,
    output logic position_coincidence_output,
    output logic jerk_filter_enable,
    output logic lowpass_filter_enable
);

    if (CYC_PER_MS < 1 || CYC_PER_MS >= (1 << MS_CNT_W)) begin : g_rate_chk
        $error("CYC_PER_MS out of range");
    end

    localparam logic [MS_CNT_W-1:0] MS_LAST = MS_CNT_W'(CYC_PER_MS - 1);

    typedef struct packed {
        logic [3:0][2:0] sync;
        logic [3:0] lvl;
        svpm_mode_t mode;
        logic [15:0] inhibit_func;
        logic [15:0] clear_func;
        logic [15:0] output4_func;
        logic [15:0] coin_func;
        logic [15:0] threshold;
        logic [15:0] judge_time;
        logic [15:0] done_time;
        logic [31:0] target;
        logic [15:0] jerk_time;
        logic [15:0] lowpass_time;
        logic [31:0] cmd_pos;
        logic [31:0] pos_err;
        logic [MS_CNT_W-1:0] ms_cnt;
        logic ms_tick;
        logic [15:0] idle_ms;
        logic [15:0] judge_ms;
        logic in_pos;
        logic coin;
        logic out4;
        logic coin_out;
        logic halt;
        logic comp_en;
        logic jerk_en;
        logic lp_en;
        logic aw_have;
        logic w_have;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } svpm_state_t;

    localparam svpm_state_t RST = '{
        mode: MODE_PULSE_POS,
        inhibit_func: RST_INHIBIT_FUNC,
        clear_func: RST_CLEAR_FUNC,
        output4_func: RST_OUTPUT4_FUNC,
        coin_func: RST_COIN_FUNC,
        threshold: RST_THRESHOLD,
        judge_time: RST_JUDGE_TIME,
        done_time: RST_DONE_TIME,
        target: RST_TARGET,
        jerk_time: RST_JERK_TIME,
        lowpass_time: RST_LOWPASS_TIME,
        comp_en: 1'b1,
        default: '0
    };

    svpm_state_t q;
    svpm_state_t d;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = data[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] clamp16(input logic [31:0] v,
                                            input logic [15:0] lim);
        return (v > {16'h0000, lim}) ? lim : v[15:0];
    endfunction

    function automatic logic polarity(input logic [15:0] func,
                                      input logic [15:0] closed_code,
                                      input logic [15:0] open_code,
                                      input logic contact);
        if (func == closed_code) begin
            return contact;
        end else if (func == open_code) begin
            return ~contact;
        end
        return 1'b0;
    endfunction

    logic [3:0] pins;
    assign pins = {error_counter_clear_input, pulse_inhibit_input,
                   pulse_dir_pin, pulse_step_pin};

    always_comb begin
        logic [31:0] wv;
        logic [31:0] abs_err;
        logic [32:0] coin_diff;
        logic [32:0] coin_abs;
        logic pulse_mode;
        logic pos_mode;
        logic inhibit_act;
        logic clear_act;
        logic step_rise;
        logic pulses_done;
        logic raw_in_pos;
        wv = '0;
        d = q;
        // Three-stage synchronisers; a level is taken when the last two stages agree.
        for (int i = 0; i < 4; i++) begin
            d.sync[i] = {q.sync[i][1:0], pins[i]};
            if (q.sync[i][1] == q.sync[i][2]) begin
                d.lvl[i] = q.sync[i][2];
            end
        end
        step_rise = (q.sync[0][1] == q.sync[0][2]) & q.sync[0][2] & ~q.lvl[0];
        pulse_mode = (q.mode == MODE_PULSE_POS);
        pos_mode = pulse_mode | (q.mode == MODE_INT_POS)
                   | (q.mode == MODE_ANA_POS);
        inhibit_act = pulse_mode & polarity(q.inhibit_func,
            FC_INHIBIT_CLOSED, FC_INHIBIT_OPEN, q.lvl[2]);
        clear_act = pulse_mode & polarity(q.clear_func,
            FC_CLEAR_CLOSED, FC_CLEAR_OPEN, q.lvl[3]);

        // Command pulse counting.
        if (step_rise && !inhibit_act) begin
            d.cmd_pos = q.lvl[1] ? q.cmd_pos - 32'h00000001
                                 : q.cmd_pos + 32'h00000001;
        end
        if (clear_act) begin
            d.cmd_pos = feedback_position;
            d.pos_err = '0;
        end else begin
            d.pos_err = q.cmd_pos - feedback_position;
        end
        d.comp_en = ~clear_act;
        d.halt = inhibit_act;

        // Millisecond time base.
        d.ms_tick = (q.ms_cnt == MS_LAST);
        d.ms_cnt = d.ms_tick ? '0 : q.ms_cnt + 1'b1;

        // Pulses count as finished after the detect time without one.
        if (step_rise && !inhibit_act) begin
            d.idle_ms = '0;
        end else if (q.ms_tick && q.idle_ms != 16'hFFFF) begin
            d.idle_ms = q.idle_ms + 16'h0001;
        end
        pulses_done = (q.idle_ms >= q.done_time);

        abs_err = q.pos_err[31] ? 32'h00000000 - q.pos_err : q.pos_err;
        raw_in_pos = pos_mode && pulses_done
                     && (abs_err < {16'h0000, q.threshold});
        if (!raw_in_pos) begin
            d.judge_ms = '0;
        end else if (q.ms_tick && q.judge_ms != 16'hFFFF) begin
            d.judge_ms = q.judge_ms + 16'h0001;
        end
        d.in_pos = raw_in_pos && (q.judge_ms >= q.judge_time);

        coin_diff = {feedback_position[31], feedback_position}
                    - {q.target[31], q.target};
        coin_abs = coin_diff[32] ? 33'h000000000 - coin_diff : coin_diff;
        d.coin = (coin_abs <= COIN_TOLERANCE);

        unique case (q.output4_func)
            FC_INPOS_CLOSED: d.out4 = q.in_pos;
            FC_INPOS_OPEN: d.out4 = ~q.in_pos;
            FC_COIN_CLOSED: d.out4 = q.coin;
            FC_COIN_OPEN: d.out4 = ~q.coin;
            default: d.out4 = 1'b0;
        endcase
        d.coin_out = polarity(q.coin_func, FC_COIN_CLOSED, FC_COIN_OPEN,
                              q.coin);
        d.jerk_en = (q.jerk_time != '0) && !pulse_mode;
        d.lp_en = (q.lowpass_time != '0);

        // Write channel.
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_have = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_have = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.aw_have && q.w_have && !q.bvalid) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            unique case (q.awaddr)
                A_MODE: begin
                    wv = merge({29'h0, q.mode}, q.wdata, q.wstrb);
                    d.mode = svpm_mode_t'(wv[2:0]);
                end
                A_INHIBIT_FUNC: begin
                    wv = merge({16'h0, q.inhibit_func}, q.wdata, q.wstrb);
                    d.inhibit_func = wv[15:0];
                end
                A_CLEAR_FUNC: begin
                    wv = merge({16'h0, q.clear_func}, q.wdata, q.wstrb);
                    d.clear_func = wv[15:0];
                end
                A_OUTPUT4_FUNC: begin
                    wv = merge({16'h0, q.output4_func}, q.wdata, q.wstrb);
                    d.output4_func = wv[15:0];
                end
                A_COIN_FUNC: begin
                    wv = merge({16'h0, q.coin_func}, q.wdata, q.wstrb);
                    d.coin_func = wv[15:0];
                end
                A_THRESHOLD: begin
                    wv = merge({16'h0, q.threshold}, q.wdata, q.wstrb);
                    d.threshold = clamp16(wv, MAX_THRESHOLD);
                end
                A_JUDGE_TIME: begin
                    wv = merge({16'h0, q.judge_time}, q.wdata, q.wstrb);
                    d.judge_time = clamp16(wv, MAX_JUDGE_TIME);
                end
                A_DONE_TIME: begin
                    wv = merge({16'h0, q.done_time}, q.wdata, q.wstrb);
                    d.done_time = clamp16(wv, MAX_DONE_TIME);
                end
                A_TARGET: begin
                    wv = merge(q.target, q.wdata, q.wstrb);
                    d.target = (wv == 32'h80000000) ? MIN_TARGET : wv;
                end
                A_JERK_TIME: begin
                    wv = merge({16'h0, q.jerk_time}, q.wdata, q.wstrb);
                    d.jerk_time = clamp16(wv, MAX_JERK_TIME);
                end
                A_LOWPASS_TIME: begin
                    wv = merge({16'h0, q.lowpass_time}, q.wdata, q.wstrb);
                    d.lowpass_time = clamp16(wv, MAX_LOWPASS_TIME);
                end
                default: d.bresp = RESP_SLVERR;
            endcase
        end

        // Read channel.
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            unique case (s_axi_araddr)
                A_MODE: d.rdata = {29'h0, q.mode};
                A_INHIBIT_FUNC: d.rdata = {16'h0, q.inhibit_func};
                A_CLEAR_FUNC: d.rdata = {16'h0, q.clear_func};
                A_OUTPUT4_FUNC: d.rdata = {16'h0, q.output4_func};
                A_COIN_FUNC: d.rdata = {16'h0, q.coin_func};
                A_THRESHOLD: d.rdata = {16'h0, q.threshold};
                A_JUDGE_TIME: d.rdata = {16'h0, q.judge_time};
                A_DONE_TIME: d.rdata = {16'h0, q.done_time};
                A_TARGET: d.rdata = q.target;
                A_JERK_TIME: d.rdata = {16'h0, q.jerk_time};
                A_LOWPASS_TIME: d.rdata = {16'h0, q.lowpass_time};
                A_STATUS: d.rdata = {22'h0, q.lvl[3], q.lvl[2], q.lp_en,
                    q.jerk_en, q.comp_en, q.halt, q.coin_out, q.out4,
                    q.coin, q.in_pos};
                A_POS_ERROR: d.rdata = q.pos_err;
                A_POS_COMMAND: d.rdata = q.cmd_pos;
                default: begin
                    d.rdata = '0;
                    d.rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready = ~q.aw_have & ~q.bvalid;
    assign s_axi_wready = ~q.w_have & ~q.bvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = ~q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign position_command = q.cmd_pos;
    assign position_error = q.pos_err;
    assign position_comp_enable = q.comp_en;
    assign motor_halt = q.halt;
    assign digital_output_four = q.out4;
    assign position_coincidence_output = q.coin_out;
    assign jerk_filter_enable = q.jerk_en;
    assign lowpass_filter_enable = q.lp_en;

endmodule // svpm_top

/* File: tb/svpm_props.sv */
`timescale 1ns/1ps
module svpm_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] feedback_position,
    input wire logic [31:0] position_command,
    input wire logic [31:0] position_error,
    input wire logic position_comp_enable,
    input wire logic motor_halt,
    input wire logic digital_output_four,
    input wire logic position_coincidence_output
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_error_calc: assert property (
        position_comp_enable && $past(position_comp_enable)
        && $past(aresetn) |-> position_error ==
        $past(position_command) - $past(feedback_position))
        else $error("position error is not command minus feedback");
    chk_clear_zero: assert property (
        !position_comp_enable |-> position_error == 32'h0)
        else $error("position error not zero while clear is active");
    chk_halt_hold: assert property (
        motor_halt && $past(motor_halt) && position_comp_enable
        |-> $stable(position_command))
        else $error("command counted while pulses are inhibited");
    chk_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response not two cycles after request");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after address");
    chk_write_refuse: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    chk_read_refuse: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
    chk_bresp_release: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held after acceptance");

    cov_halt: cover property ($rose(motor_halt));
    cov_clear: cover property ($fell(position_comp_enable));
    cov_inpos: cover property ($rose(digital_output_four));
    cov_coin: cover property ($rose(position_coincidence_output));
endmodule // svpm_props

bind svpm_top svpm_props u_props (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .feedback_position, .position_command,
    .position_error, .position_comp_enable, .motor_halt,
    .digital_output_four, .position_coincidence_output
);

/* File: tb/svpm_host.sv */
`timescale 1ns/1ps
module svpm_host (
    input wire logic aclk,
    output logic pulse_step_pin,
    output logic pulse_dir_pin,
    output logic pulse_inhibit_input,
    output logic error_counter_clear_input
);
    initial begin
        pulse_step_pin = 1'b0;
        pulse_dir_pin = 1'b0;
        pulse_inhibit_input = 1'b0;
        error_counter_clear_input = 1'b0;
    end

    // Sends step pulses, each level held four clocks, then lets them settle.
    task automatic send(input int n, input logic down);
        pulse_dir_pin <= down;
        repeat (n) begin
            repeat (4) @(posedge aclk);
            pulse_step_pin <= 1'b1;
            repeat (4) @(posedge aclk);
            pulse_step_pin <= 1'b0;
        end
        repeat (8) @(posedge aclk);
    endtask

    // Sets both contacts, where 1 means closed, and waits for the sync.
    task automatic contacts(input logic inh, input logic clr);
        pulse_inhibit_input <= inh;
        error_counter_clear_input <= clr;
        repeat (8) @(posedge aclk);
    endtask
endmodule // svpm_host

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import svpm_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [31:0] feedback_position = 32'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, position_comp_enable, motor_halt;
    logic digital_output_four, position_coincidence_output;
    logic jerk_filter_enable, lowpass_filter_enable;
    logic pulse_step_pin, pulse_dir_pin;
    logic pulse_inhibit_input, error_counter_clear_input;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, position_command, position_error;
    logic [31:0] exp_cmd = 32'h0;
    int num_errors = 0;
    int num_checks = 0;

    always #5 aclk = ~aclk;

    svpm_top #(.CYC_PER_MS(10)) DUT (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pulse_step_pin, .pulse_dir_pin,
        .pulse_inhibit_input, .error_counter_clear_input,
        .feedback_position, .position_command, .position_error,
        .position_comp_enable, .motor_halt, .digital_output_four,
        .position_coincidence_output, .jerk_filter_enable,
        .lowpass_filter_enable
    );
    svpm_host u_host (
        .aclk, .pulse_step_pin, .pulse_dir_pin, .pulse_inhibit_input,
        .error_counter_clear_input
    );

    task automatic complete_run;
        if (num_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 50) num_errors++;
        if (n == 50) complete_run;
        check(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 50) num_errors++;
        if (n == 50) complete_run;
        check(s_axi_rdata, ed);
        check(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
    endtask

    task automatic t_regs;
        logic [31:0] ev [10];
        ev = '{32'h19, 32'h11, 32'h9, 32'h1F, 32'h28, 32'hA, 32'h2,
               32'hA, 32'hA, 32'hA};
        rd(A_MODE, 32'h0, RESP_OKAY);
        for (int i = 0; i < 10; i++) rd(8'(A_INHIBIT_FUNC + 4 * i), ev[i],
            RESP_OKAY);
        rd(8'h3C, 32'h0, RESP_SLVERR);
        wr(8'h3C, 32'h5, RESP_SLVERR);
        wr(A_THRESHOLD, 32'hFFFF, RESP_OKAY);
        rd(A_THRESHOLD, 32'h7D00, RESP_OKAY);
        wr(A_THRESHOLD, 32'h28, RESP_OKAY);
        wr(A_TARGET, 32'h80000000, RESP_OKAY);
        rd(A_TARGET, 32'h80000001, RESP_OKAY);
        wr(A_TARGET, 32'hA, RESP_OKAY);
    endtask

    task automatic t_count;
        wr(A_JUDGE_TIME, 32'h0, RESP_OKAY);
        u_host.send(5, 1'b0);
        u_host.send(2, 1'b1);
        exp_cmd = 32'h3;
        check(digital_output_four, 1'b0);
        check(position_command, exp_cmd);
        check(position_error, exp_cmd);
        repeat (30) @(posedge aclk);
        check(digital_output_four, 1'b1);
        wr(A_JUDGE_TIME, 32'hA, RESP_OKAY);
        rd(A_POS_COMMAND, exp_cmd, RESP_OKAY);
    endtask

    task automatic t_inhibit;
        u_host.contacts(1'b1, 1'b0);
        check(motor_halt, 1'b1);
        u_host.send(3, 1'b0);
        check(position_command, exp_cmd);
        u_host.contacts(1'b0, 1'b0);
        check(motor_halt, 1'b0);
        wr(A_INHIBIT_FUNC, 32'h1A, RESP_OKAY);
        u_host.contacts(1'b0, 1'b0);
        check(motor_halt, 1'b1);
        u_host.contacts(1'b1, 1'b0);
        check(motor_halt, 1'b0);
        u_host.send(1, 1'b0);
        exp_cmd = exp_cmd + 32'h1;
        check(position_command, exp_cmd);
        u_host.contacts(1'b0, 1'b0);
        wr(A_INHIBIT_FUNC, 32'h19, RESP_OKAY);
    endtask

    task automatic t_clear;
        feedback_position <= 32'd1234;
        u_host.contacts(1'b0, 1'b1);
        check(position_comp_enable, 1'b0);
        u_host.send(2, 1'b0);
        check(position_error, 32'h0);
        u_host.contacts(1'b0, 1'b0);
        exp_cmd = 32'd1234;
        check(position_command, exp_cmd);
        check(position_comp_enable, 1'b1);
        wr(A_CLEAR_FUNC, 32'h12, RESP_OKAY);
        u_host.contacts(1'b0, 1'b0);
        check(position_comp_enable, 1'b0);
        u_host.contacts(1'b0, 1'b1);
        check(position_comp_enable, 1'b1);
        u_host.contacts(1'b0, 1'b0);
        wr(A_CLEAR_FUNC, 32'h11, RESP_OKAY);
        feedback_position <= 32'd1230;
        repeat (4) @(posedge aclk);
        check(position_error, 32'h4);
    endtask

    task automatic t_inpos;
        feedback_position <= exp_cmd - 32'd1000;
        repeat (150) @(posedge aclk);
        check(digital_output_four, 1'b0);
        feedback_position <= exp_cmd + 32'd5;
        repeat (50) @(posedge aclk);
        check(digital_output_four, 1'b0);
        repeat (100) @(posedge aclk);
        check(digital_output_four, 1'b1);
        wr(A_OUTPUT4_FUNC, 32'hA, RESP_OKAY);
        repeat (4) @(posedge aclk);
        check(digital_output_four, 1'b0);
        wr(A_OUTPUT4_FUNC, 32'h9, RESP_OKAY);
        wr(A_THRESHOLD, 32'h0, RESP_OKAY);
        repeat (4) @(posedge aclk);
        check(digital_output_four, 1'b0);
        wr(A_THRESHOLD, 32'h28, RESP_OKAY);
    endtask

    task automatic t_coin;
        logic [31:0] fb [4];
        logic ec [4];
        fb = '{32'd110, 32'd111, 32'hFFFFFFA6, 32'hFFFFFFA5};
        ec = '{1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++) begin
            feedback_position <= fb[i];
            repeat (4) @(posedge aclk);
            check(position_coincidence_output, ec[i]);
        end
        feedback_position <= fb[0];
        wr(A_COIN_FUNC, 32'h20, RESP_OKAY);
        repeat (4) @(posedge aclk);
        check(position_coincidence_output, 1'b0);
        wr(A_COIN_FUNC, 32'h1F, RESP_OKAY);
    endtask

    task automatic t_filters;
        for (int m = 7; m >= 0; m--) begin
            wr(A_MODE, 32'(m), RESP_OKAY);
            repeat (3) @(posedge aclk);
            check(jerk_filter_enable, m != 0);
            check(lowpass_filter_enable, 1'b1);
        end
        wr(A_MODE, 32'h1, RESP_OKAY);
        wr(A_JERK_TIME, 32'h0, RESP_OKAY);
        wr(A_LOWPASS_TIME, 32'h0, RESP_OKAY);
        repeat (3) @(posedge aclk);
        check(jerk_filter_enable, 1'b0);
        check(lowpass_filter_enable, 1'b0);
    endtask

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (5) @(posedge aclk);
        t_regs;
        t_count;
        t_inhibit;
        t_clear;
        t_inpos;
        t_coin;
        t_filters;
        complete_run;
    end
endmodule // testbench
